// File: design/sasc_consts.vh
`ifndef SASC_CONSTS_VH
`define SASC_CONSTS_VH

// Register byte offsets
`define SASC_REG_CTRL 8'h00
`define SASC_REG_STATUS 8'h04
`define SASC_REG_RESULT 8'h08

// Control register fields
`define SASC_CTRL_FMT 0
`define SASC_CTRL_EXT 1
`define SASC_CTRL_PWD 2
`define SASC_CTRL_RESET 3'h0

// Status register fields
`define SASC_ST_CONV 0
`define SASC_ST_ISHIFT 1
`define SASC_ST_BUSY_N 2

// Reset values and response codes
`define SASC_RESULT_RESET 16'h0000
`define SASC_RESP_OKAY 2'h0
`define SASC_RESP_SLVERR 2'h2

// Word width and timing
`define SASC_BITS 16
`define SASC_CLK_MHZ 125
`define SASC_CONV_NS 3000
`define SASC_DCLK_DLY_NS 260
`define SASC_DCLK_PER_NS 150
`define SASC_DCLK_LEAD 4
`define SASC_STEP_CYC ((`SASC_CONV_NS * `SASC_CLK_MHZ / 1000) / `SASC_BITS)
`define SASC_DLY_CYC ((`SASC_DCLK_DLY_NS * `SASC_CLK_MHZ + 999) / 1000)
`define SASC_PER_CYC (`SASC_DCLK_PER_NS * `SASC_CLK_MHZ / 1000)
`define SASC_HIGH_CYC (`SASC_PER_CYC / 2)

`endif

// File: design/sasc_core.v
`timescale 1ns/1ps
`include "sasc_consts.vh"
// Summary of operation
// - Format select high gives straight binary, low gives two's complement.
// - External clock mode: host drives shift clock, data follows its edges.
// - Internal mode: each conversion sends previous result on 16 generated clock pulses.
// - Internal mode: shift clock pin held low outside conversions.
// - External mode: read enable event emits a word start pulse on shift clock.
// - External mode, select low and read high: chain input follows 16 clocks later.
// - Internal mode: each data bit stable over both shift clock edges.
// - Internal mode: between conversions data holds chain input level captured at start.
// - Select low, read/convert falling: hold sample and start conversion.
// - External mode, select low, read/convert rising: enable serial result output.
// - Select ORed with read/convert; select falling starts, or in external mode enables, per level.
// - Busy low for whole conversion; result valid as busy rises.
// - Power down refuses starts; in internal mode the shift register keeps the previous result.
// - Approximation register cleared at start; further starts ignored meanwhile.
// - Result decided one bit per step, most significant first.
// - Conversion end copies result into output shift register.
// - Two's complement full scale 7FFF/8000; two's complement flips the top bit of straight binary.
module sasc_core (
	input wire clk,
	input wire resetn,
	input wire ce,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	output reg [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	input wire read_convert,
	input wire select_n,
	input wire chain_in,
	input wire comp_high,
	input wire shift_clock_pin_in,
	output reg shift_clock_pin_out,
	output reg shift_clock_pin_oe,
	output reg word_start,
	output reg serial_data,
	output reg busy_n,
	output reg [15:0] dac_code
);
	localparam integer STEP_LAST = `SASC_STEP_CYC - 1;
	localparam integer DLY_LAST = `SASC_DLY_CYC - 1;
	localparam integer PER_LAST = `SASC_PER_CYC - 1;
	localparam integer RISE_AT = `SASC_DCLK_LEAD - 1;
	localparam integer FALL_AT = `SASC_DCLK_LEAD + `SASC_HIGH_CYC - 1;

	// Straight binary is the natural comparator code; two's complement flips the top bit
	function [15:0] sasc_fmt;
		input [15:0] code;
		input straight;
		begin
			sasc_fmt = straight ? code : {~code[15], code[14:0]};
		end
	endfunction

	// Control register and derived mode bits
	reg [2:0] ctrl;
	wire fmt_straight = ctrl[`SASC_CTRL_FMT];
	wire ext_mode = ctrl[`SASC_CTRL_EXT];
	wire power_down = ctrl[`SASC_CTRL_PWD];

	// Pin synchronisers: stage one feeds stage two only
	reg [4:0] sync1;
	reg [4:0] sync2;
	reg comb_prev;
	reg rd_prev;
	reg dclk_prev;
	wire rc_s = sync2[0];
	wire cs_n_s = sync2[1];
	wire tag_s = sync2[2];
	wire dclk_s = sync2[3];
	wire comp_s = sync2[4];

	// Select is ORed with read/convert; falling OR starts, rising read-level enables
	wire comb = cs_n_s | rc_s;
	wire rd_level = ~cs_n_s & rc_s;
	wire start_edge = comb_prev & ~comb;
	wire rd_edge = rd_level & ~rd_prev;
	wire ext_rise = dclk_s & ~dclk_prev;

	// Conversion state
	reg converting;
	reg just_done;
	reg [3:0] bit_sel;
	reg [4:0] step_cnt;
	reg [15:0] sar;
	reg [15:0] shreg;
	reg [15:0] result;
	reg tag_held;

	// Internal shift clock generator state
	reg ishift;
	reg pre_run;
	reg [5:0] pre_cnt;
	reg [4:0] pcnt;
	reg [3:0] ibit;

	// External read state
	reg sync_pend;

	// Host who lets the OR stay low at busy rise gets an immediate restart
	wire start_req = start_edge | (just_done & ~comb);

	always @(posedge clk) begin
		if (!resetn) begin
			sync1 <= 5'h03; // Idle level, read and select high, so no false start follows reset
			sync2 <= 5'h03;
			comb_prev <= 1'b1;
			rd_prev <= 1'b0;
			dclk_prev <= 1'b0;
		end else if (ce) begin
			sync1 <= {comp_high, shift_clock_pin_in, chain_in, select_n, read_convert};
			sync2 <= sync1;
			comb_prev <= comb;
			rd_prev <= rd_level;
			dclk_prev <= dclk_s;
		end
	end

	// Successive approximation, output shift register and pin drivers
	always @(posedge clk) begin
		if (!resetn) begin
			converting <= 1'b0;
			just_done <= 1'b0;
			bit_sel <= 4'hF;
			step_cnt <= 5'h00;
			sar <= 16'h0000;
			shreg <= `SASC_RESULT_RESET;
			result <= `SASC_RESULT_RESET;
			tag_held <= 1'b0;
			busy_n <= 1'b1;
			dac_code <= 16'h0000;
			ishift <= 1'b0;
			pre_run <= 1'b0;
			pre_cnt <= 6'h00;
			pcnt <= 5'h00;
			ibit <= 4'h0;
			sync_pend <= 1'b0;
			word_start <= 1'b0;
			serial_data <= 1'b0;
			shift_clock_pin_out <= 1'b0;
			shift_clock_pin_oe <= 1'b1;
		end else if (ce) begin
			just_done <= 1'b0;
			shift_clock_pin_oe <= ~ext_mode;
			if (!converting) begin
				// Starts are refused in power down; the shift register is left alone
				if (start_req && !power_down) begin
					converting <= 1'b1;
					busy_n <= 1'b0;
					sar <= 16'h0000;
					bit_sel <= 4'hF;
					step_cnt <= 5'h00;
					tag_held <= tag_s;
					if (!ext_mode) begin
						pre_run <= 1'b1;
						pre_cnt <= 6'h00;
					end
				end
			end else begin
				// Trial bit set at step start, kept or dropped at step end; new starts ignored
				step_cnt <= step_cnt + 5'h01;
				if (step_cnt == 5'h00) sar[bit_sel] <= 1'b1;
				if (step_cnt == STEP_LAST[4:0]) begin
					step_cnt <= 5'h00;
					sar[bit_sel] <= comp_s;
					bit_sel <= bit_sel - 4'h1;
					if (bit_sel == 4'h0) begin
						converting <= 1'b0;
						just_done <= 1'b1;
						busy_n <= 1'b1;
						result <= sasc_fmt({sar[15:1], comp_s}, fmt_straight);
					end
				end
			end
			dac_code <= sar;

			// Delay from start to first generated pulse
			if (pre_run) begin
				pre_cnt <= pre_cnt + 6'h01;
				if (pre_cnt == DLY_LAST[5:0]) begin
					pre_run <= 1'b0;
					ishift <= 1'b1;
					pcnt <= 5'h00;
					ibit <= 4'h0;
				end
			end

			// Data changes late in the low phase, a few cycles before the rise, so it is steady at both clock edges
			if (ishift) begin
				pcnt <= pcnt + 5'h01;
				if (pcnt == RISE_AT[4:0]) shift_clock_pin_out <= 1'b1;
				if (pcnt == FALL_AT[4:0]) shift_clock_pin_out <= 1'b0;
				if (pcnt == PER_LAST[4:0]) begin
					pcnt <= 5'h00;
					shreg <= {shreg[14:0], tag_held};
					ishift <= (ibit != 4'hF);
					ibit <= ibit + 4'h1;
				end
			end else begin
				shift_clock_pin_out <= 1'b0;
			end

			// External mode: first host edge after enable marks the word, later edges shift;
			// an enable that meets a host edge still arms the pending word start
			if (ext_mode && ext_rise) begin
				word_start <= 1'b0;
				if (rd_level) begin
					if (sync_pend) begin
						word_start <= 1'b1;
						sync_pend <= 1'b0;
					end else begin
						shreg <= {shreg[14:0], tag_s};
					end
				end
			end
			if (rd_edge && ext_mode) sync_pend <= 1'b1;

			// End of conversion load wins over any shift in the same cycle
			if (converting && step_cnt == STEP_LAST[4:0] && bit_sel == 4'h0) begin
				shreg <= sasc_fmt({sar[15:1], comp_s}, fmt_straight);
			end

			// Serial data pin
			if (ext_mode) begin
				serial_data <= shreg[15];
			end else if (ishift) begin
				serial_data <= shreg[15];
			end else begin
				serial_data <= tag_held;
			end
		end
	end

	// AXI4-Lite write channel: one write at a time, address and data in either order
	reg aw_got;
	reg w_got;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	always @(posedge clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SASC_RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			ctrl <= `SASC_CTRL_RESET;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_got && w_got && !s_axi_bvalid) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `SASC_RESP_OKAY;
				// Read-only registers swallow writes; anything else unmapped is an error
				if (aw_addr == `SASC_REG_CTRL) begin
					if (w_strb[0]) ctrl <= w_data[2:0];
				end else if (aw_addr != `SASC_REG_STATUS && aw_addr != `SASC_REG_RESULT) begin
					s_axi_bresp <= `SASC_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel: data is captured when the address is taken
	always @(posedge clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SASC_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `SASC_RESP_OKAY;
				case (s_axi_araddr)
					`SASC_REG_CTRL: s_axi_rdata <= {29'h00000000, ctrl};
					`SASC_REG_STATUS: s_axi_rdata <= {29'h00000000, busy_n, ishift, converting};
					`SASC_REG_RESULT: s_axi_rdata <= {16'h0000, result};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `SASC_RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// File: bench/sasc_host.sv
`timescale 1ns/1ps
// Host side: shift clock source and comparator stand-in
module sasc_host (
	input wire run,
	input wire [15:0] vin,
	input wire [15:0] dac_code,
	output reg host_sck,
	output wire comp_high
);
	// Trial bit kept while the input is at or above the trial code
	assign comp_high = (vin >= dac_code);
	// 64 ns clock, parked low between frames, phase offset from clk
	initial begin
		host_sck = 1'h0;
		#3;
		forever begin
			#32;
			host_sck = run ? ~host_sck : 1'h0;
		end
	end
endmodule

// File: bench/sasc_sva.sv
`timescale 1ns/1ps
module sasc_sva (
	input wire clk,
	input wire resetn,
	input wire s_axi_rvalid,
	input wire [1:0] s_axi_rresp,
	input wire shift_clock_pin_out,
	input wire shift_clock_pin_oe,
	input wire word_start,
	input wire serial_data,
	input wire busy_n,
	input wire [15:0] dac_code
);
	reg [8:0] low_cnt;
	reg [4:0] n_pulse;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Length of the running conversion and pulses sent in it
	always @(posedge clk) begin
		if (!resetn || busy_n)
			low_cnt <= 9'h0;
		else
			low_cnt <= low_cnt + 9'h1;
		if (!resetn || $fell(busy_n))
			n_pulse <= 5'h0;
		else if ($rose(shift_clock_pin_out))
			n_pulse <= n_pulse + 5'h1;
	end
	a_busy_length: assert property ($rose(busy_n) |-> low_cnt >= 367 && low_cnt <= 369) else $error("len");
	a_pulse_count: assert property ($rose(busy_n) && shift_clock_pin_oe |-> n_pulse == 5'h10) else $error("n");
	a_sclk_idle: assert property (busy_n |-> !shift_clock_pin_out) else $error("idle");
	a_sclk_high: assert property ($rose(shift_clock_pin_out) |=> shift_clock_pin_out [*8] ##1 !shift_clock_pin_out)
		else $error("high");
	a_data_stable: assert property ($changed(shift_clock_pin_out) |-> $stable(serial_data)) else $error("d");
	a_sclk_owner: assert property (shift_clock_pin_out |-> shift_clock_pin_oe && !busy_n) else $error("own");
	a_msb_trial: assert property ($fell(busy_n) |-> ##[0:30] dac_code == 16'h8000) else $error("msb");
	a_start_ext: assert property (word_start |-> !shift_clock_pin_oe) else $error("ws");
	// Main scenarios reached
	cover property ($rose(busy_n));
	cover property ($rose(word_start));
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind sasc_core sasc_sva u_sva (.clk(clk), .resetn(resetn), .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp),
	.shift_clock_pin_out(shift_clock_pin_out), .shift_clock_pin_oe(shift_clock_pin_oe), .word_start(word_start),
	.serial_data(serial_data), .busy_n(busy_n), .dac_code(dac_code));

// File: bench/test_sar_adc_serial_control.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked = checked + 1; if ((e) !== (s)) begin n_errors = n_errors + 1; \
	$display("MISMATCH %s exp %h got %h", nm, e, s); end end
module test_sar_adc_serial_control;
	reg clk = 1'h0, resetn = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
	reg rc = 1'h1, sel_n = 1'h0, chain = 1'h0, run = 1'h0, sck_d = 1'h0, ws_seen = 1'h0, fmt, lvl;
	reg [7:0] awa = 8'h00, ara = 8'h00;
	reg [31:0] wd = 32'h0, seed = 32'h4D0CA66C, xs = 32'h0, rd;
	reg [15:0] vin = 16'h0, prev = 16'h0, sh = 16'h0, v;
	reg [1:0] rs;
	wire awr, wrr, bv, arr, rv, sck, oe, ws, sd, bsy, cmp, hsck;
	wire [1:0] br, rr;
	wire [31:0] rdt;
	wire [15:0] dac;
	integer n_errors = 0, checked = 0, i, k;
	sasc_core dut (.clk(clk), .resetn(resetn), .ce(1'h1), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.s_axi_rdata(rdt), .s_axi_rresp(rr), .read_convert(rc), .select_n(sel_n), .chain_in(chain),
		.comp_high(cmp), .shift_clock_pin_in(oe ? sck : hsck), .shift_clock_pin_out(sck),
		.shift_clock_pin_oe(oe), .word_start(ws), .serial_data(sd), .busy_n(bsy), .dac_code(dac));
	sasc_host host (.run(run), .vin(vin), .dac_code(dac), .host_sck(hsck), .comp_high(cmp));
	initial forever #4 clk = ~clk;
	// Sample generated pulses one clk after the rise; host data one period late, clear of the sync delay
	always @(posedge clk) begin
		sck_d <= sck;
		if (sck && !sck_d) sh <= {sh[14:0], sd};
		if (ws) ws_seen <= 1'h1;
	end
	always @(posedge hsck) xs <= {xs[30:0], sd};
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [15:0] fx(input [15:0] c, input f);
		fx = f ? c : {~c[15], c[14:0]};
	endfunction
	task give_verdict;
		begin
			if (n_errors == 0 && checked > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	task lim;
		if (k >= 3000) begin
			n_errors = n_errors + 1;
			give_verdict;
		end
	endtask
	task wt(input b);
		begin
			for (k = 0; k < 3000 && bsy !== b; k = k + 1) @(posedge clk);
			lim;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] e);
		begin
			@(posedge clk);
			awa <= a;
			wd <= d;
			awv <= 1'h1;
			wv <= 1'h1;
			bre <= 1'h1;
			for (k = 0; k < 3000 && !(bv && bre); k = k + 1) begin
				@(posedge clk);
				if (awr) awv <= 1'h0;
				if (wrr) wv <= 1'h0;
			end
			bre <= 1'h0;
			lim;
			`CHK("bresp", e, br)
		end
	endtask
	task rdr(input [7:0] a);
		begin
			@(posedge clk);
			ara <= a;
			arv <= 1'h1;
			rre <= 1'h1;
			for (k = 0; k < 3000 && !(rv && rre); k = k + 1) begin
				@(posedge clk);
				if (arr) arv <= 1'h0;
			end
			rre <= 1'h0;
			rd = rdt;
			rs = rr;
			lim;
		end
	endtask
	// Start, return high early, try a restart mid-conversion, then leave acquisition time
	task conv;
		begin
			@(posedge clk);
			rc <= 1'h0;
			wt(1'h0);
			rc <= 1'h1;
			repeat (40) @(posedge clk);
			rc <= 1'h0;
			repeat (4) @(posedge clk);
			rc <= 1'h1;
			wt(1'h1);
			repeat (260) @(posedge clk);
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'h1;
		rdr(8'h00);
		`CHK("ctrl", 32'h0, rd)
		rdr(8'h04);
		`CHK("status", 32'h4, rd)
		rdr(8'h0C);
		`CHK("unmapped", 2'h2, rs)
		wr(8'h10, 32'h1, 2'h2);
		for (i = 0; i < 8; i = i + 1) begin
			seed = lfsr(seed);
			v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[15:0];
			fmt = (i > 1) && seed[16];
			lvl = seed[17];
			wr(8'h00, {30'h0, i > 5, fmt}, 2'h0);
			vin <= v;
			chain <= lvl;
			conv;
			rdr(8'h08);
			`CHK("result", {16'h0, fx(v, fmt)}, rd)
			if (i < 6) begin
				`CHK("int_word", prev, sh)
				`CHK("idle_data", lvl, sd)
			end else begin
				sel_n <= 1'h1;
				repeat (4) @(posedge clk);
				ws_seen <= 1'h0;
				sel_n <= 1'h0;
				repeat (6) @(posedge clk);
				run = 1'h1;
				repeat (33) @(posedge hsck);
				run = 1'h0;
				@(posedge clk);
				`CHK("ext_word", {fx(v, fmt), {16{lvl}}}, xs)
				`CHK("word_start", 1'h1, ws_seen)
			end
			prev = fx(v, fmt);
		end
		wr(8'h00, 32'h4, 2'h0);
		vin <= ~v; // A start that slipped through would change the stored result
		rc <= 1'h0;
		for (k = 0; k < 40 && bsy; k = k + 1) @(posedge clk);
		rc <= 1'h1;
		`CHK("pd_busy", 1'h1, bsy)
		rdr(8'h08);
		`CHK("pd_result", {16'h0, prev}, rd)
		give_verdict;
	end
endmodule
